// *** logic/csm_defs.svh ***
// Register offsets, field positions and reset values of the sensor status map
`ifndef CSM_DEFS_SVH
`define CSM_DEFS_SVH

`define CSM_IDX_PRODUCT_IDENTIFIER   8'h00
`define CSM_IDX_FIRMWARE_REVISION    8'h01
`define CSM_IDX_SYSTEM_FLAGS         8'h10
`define CSM_IDX_DETECTION_STATUS     8'h31
`define CSM_IDX_SENSE_COUNT_HIGH     8'h42
`define CSM_IDX_SENSE_COUNT_LOW      8'h43
`define CSM_IDX_DEFAULT_POINTER      8'hC8
`define CSM_OFF_IRQ_STATUS           12'h400
`define CSM_OFF_IRQ_MASK             12'h404
`define CSM_OFF_LIVE_POINTER         12'h408

`define CSM_SYS_POLARITY_BIT         5
`define CSM_SYS_HALT_BIT             4
`define CSM_SYS_SLOW_BIT             3
`define CSM_SYS_TUNING_BIT           2
`define CSM_SYS_FULLSPEED_BIT        0
`define CSM_STS_TOUCH_BIT            1
`define CSM_STS_PROX_BIT             0

`define CSM_IRQ_TOUCH_RISE_BIT       0
`define CSM_IRQ_PROX_RISE_BIT        1
`define CSM_IRQ_RESEED_BIT           2
`define CSM_IRQ_WINDOW_BIT           3
`define CSM_IRQ_WIDTH                4

`define CSM_RST_DEFAULT_POINTER      8'h00
`define CSM_RST_IRQ_MASK             4'h0
`define CSM_PRODUCT_ID_VALUE         8'hA5 // Arbitrary value
`define CSM_FIRMWARE_REV_VALUE       8'h01 // Arbitrary value

`endif

// *** logic/csm_pkg.sv ***
// Types shared by the sensor status map
package csm_pkg;
	typedef struct packed {
		logic        polarity_high;
		logic        ltafilter_halt;
		logic        slow_sample_flag;
		logic        auto_tuning;
		logic        full_speed;
		logic        touch;
		logic        prox;
		logic        prox_debounced;
		logic [15:0] count;
	} csm_sense_s;

	typedef struct packed {
		logic        reseed;
		logic [15:0] reseed_value;
	} csm_reseed_s;
endpackage

// *** logic/csm_status_map.sv ***
// APB register map of a single-channel capacitive proximity and touch sensor
`timescale 1ns/1ps
`include "csm_defs.svh"

module csm_status_map
	import csm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire csm_sense_s  sense_in,
	input  wire logic        window_start_pin,
	output logic      [7:0]  access_pointer,
	output csm_reseed_s      reseed_out,
	output logic             irq
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	csm_sense_s sense_reg;
	logic       win_reg;
	logic       window_rise;
	logic       touch_rise;
	logic       prox_rise;

	// Counts may be torn across the sync; sensing core must hold them stable
	csm_sync2 #(
		.WIDTH($bits(csm_sense_s))
	) u_sense_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (sense_in),
		.dout    (sense_reg)
	);

	csm_sync2 #(
		.WIDTH(1)
	) u_win_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (window_start_pin),
		.dout    (win_reg)
	);

	// ****************************************
	// Edge events
	// ****************************************
	csm_rise_detect u_win_rise (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (win_reg),
		.rise    (window_rise)
	);

	csm_rise_detect u_touch_rise (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (sense_reg.touch),
		.rise    (touch_rise)
	);

	csm_rise_detect u_prox_rise (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (sense_reg.prox),
		.rise    (prox_rise)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	logic        setup_phase;
	logic        access_phase;
	logic        wr_access;
	logic        rd_access;
	logic [11:0] idx_addr_preset;
	logic        wr_preset;
	logic        wr_live_pointer;
	logic        wr_irq_status;
	logic        wr_irq_mask;

	assign setup_phase     = psel && !penable;
	assign access_phase    = psel && penable;
	assign wr_access       = access_phase && pwrite;
	// Read data is latched at setup so it already stands in the access cycle
	assign rd_access       = setup_phase && !pwrite;
	assign idx_addr_preset = {2'h0, `CSM_IDX_DEFAULT_POINTER, 2'h0};

	// Writes land only at the access edge, when the answer is sampled
	assign wr_preset       = wr_access && paddr == idx_addr_preset;
	assign wr_live_pointer = wr_access && paddr == `CSM_OFF_LIVE_POINTER;
	assign wr_irq_status   = wr_access && paddr == `CSM_OFF_IRQ_STATUS;
	assign wr_irq_mask     = wr_access && paddr == `CSM_OFF_IRQ_MASK;

	// ****************************************
	// Default pointer preset and access pointer
	// ****************************************
	logic [7:0] default_pointer_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			default_pointer_reg <= `CSM_RST_DEFAULT_POINTER;
		end else if (wr_preset) begin
			default_pointer_reg <= pwdata[7:0];
		end
	end

	// Window load wins over a same-cycle pointer write
	// load on window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			access_pointer <= `CSM_RST_DEFAULT_POINTER;
		end else if (window_rise) begin
			access_pointer <= default_pointer_reg;
		end else if (wr_live_pointer) begin
			access_pointer <= pwdata[7:0];
		end
	end

	// ****************************************
	// Average reseed
	// ****************************************
	logic reseed_event;

	assign reseed_event = touch_rise && !sense_reg.prox_debounced;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reseed_out <= '0;
		end else begin
			reseed_out.reseed       <= reseed_event;
			reseed_out.reseed_value <= sense_reg.count;
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	logic [`CSM_IRQ_WIDTH-1:0] irq_status_reg;
	logic [`CSM_IRQ_WIDTH-1:0] irq_mask_reg;
	logic [`CSM_IRQ_WIDTH-1:0] irq_events;
	logic [`CSM_IRQ_WIDTH-1:0] irq_clear;
	logic [`CSM_IRQ_WIDTH-1:0] irq_status_next;

	always_comb begin
		irq_events = '0;
		irq_events[`CSM_IRQ_TOUCH_RISE_BIT] = touch_rise;
		irq_events[`CSM_IRQ_PROX_RISE_BIT]  = prox_rise;
		irq_events[`CSM_IRQ_RESEED_BIT]     = reseed_event;
		irq_events[`CSM_IRQ_WINDOW_BIT]     = window_rise;
	end

	assign irq_clear       = wr_irq_status ? pwdata[`CSM_IRQ_WIDTH-1:0] : '0;
	// Set wins over a same-cycle clear
	assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= irq_status_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= `CSM_RST_IRQ_MASK;
		end else if (wr_irq_mask) begin
			irq_mask_reg <= pwdata[`CSM_IRQ_WIDTH-1:0];
		end
	end

	// Built from the next status so the line rises with its bit, not a cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_next & irq_mask_reg);
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	logic [7:0]  sys_flags;
	logic [7:0]  det_status;
	logic [31:0] rd_next;
	logic        err_next;

	always_comb begin
		sys_flags  = 8'h00;
		det_status = 8'h00;
		sys_flags[`CSM_SYS_POLARITY_BIT]  = sense_reg.polarity_high;
		sys_flags[`CSM_SYS_HALT_BIT]      = sense_reg.ltafilter_halt;
		sys_flags[`CSM_SYS_SLOW_BIT]      = sense_reg.slow_sample_flag;
		sys_flags[`CSM_SYS_TUNING_BIT]    = sense_reg.auto_tuning;
		sys_flags[`CSM_SYS_FULLSPEED_BIT] = sense_reg.full_speed;
		det_status[`CSM_STS_TOUCH_BIT]    = sense_reg.touch;
		det_status[`CSM_STS_PROX_BIT]     = sense_reg.prox;
	end

	// Indexed registers sit at four times their byte index; IRQ and live pointer registers at fixed offsets
	always_comb begin
		rd_next  = 32'h0000_0000;
		err_next = 1'b0;
		if (paddr == {2'h0, `CSM_IDX_PRODUCT_IDENTIFIER, 2'h0}) begin
			rd_next[7:0] = `CSM_PRODUCT_ID_VALUE;
		end else if (paddr == {2'h0, `CSM_IDX_FIRMWARE_REVISION, 2'h0}) begin
			rd_next[7:0] = `CSM_FIRMWARE_REV_VALUE;
		end else if (paddr == {2'h0, `CSM_IDX_SYSTEM_FLAGS, 2'h0}) begin
			rd_next[7:0] = sys_flags;
		end else if (paddr == {2'h0, `CSM_IDX_DETECTION_STATUS, 2'h0}) begin
			rd_next[7:0] = det_status;
		end else if (paddr == {2'h0, `CSM_IDX_SENSE_COUNT_HIGH, 2'h0}) begin
			rd_next[7:0] = sense_reg.count[15:8];
		end else if (paddr == {2'h0, `CSM_IDX_SENSE_COUNT_LOW, 2'h0}) begin
			rd_next[7:0] = sense_reg.count[7:0];
		end else if (paddr == idx_addr_preset) begin
			rd_next[7:0] = default_pointer_reg;
		end else if (paddr == `CSM_OFF_IRQ_STATUS) begin
			rd_next[`CSM_IRQ_WIDTH-1:0] = irq_status_reg;
		end else if (paddr == `CSM_OFF_IRQ_MASK) begin
			rd_next[`CSM_IRQ_WIDTH-1:0] = irq_mask_reg;
		end else if (paddr == `CSM_OFF_LIVE_POINTER) begin
			rd_next[7:0] = access_pointer;
		end else begin
			err_next = 1'b1;
		end
	end

	// ****************************************
	// Bus answer
	// ****************************************
	// Answer one cycle after setup so outputs stay registered; no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	// Unmapped reads and writes alike answer with an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup_phase && err_next;
		end
	end

	// Read data holds until the next read setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_access) begin
			prdata <= rd_next;
		end
	end

endmodule

// ****************************************
// Two-flop synchroniser
// ****************************************
module csm_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg;

	// Only the second flop feeds logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			dout     <= '0;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end

endmodule

// ****************************************
// Rising edge detector
// ****************************************
module csm_rise_detect (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic level,
	output logic      rise
);
	logic level_prev_reg;

	// Cleared to the idle low level so reset gives no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_prev_reg <= 1'b0;
		end else begin
			level_prev_reg <= level;
		end
	end

	assign rise = level && !level_prev_reg;

endmodule

// *** sim/csm_host_model.sv ***
// Host controller model: APB master and comms window starts
`timescale 1ns/1ps
module csm_host_model (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	output logic             window_start_pin
);
	initial begin
		{psel, penable, pwrite, paddr, pwdata, window_start_pin} = '0;
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 64);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released bus must not look valid
		paddr <= ~a;
		pwdata <= ~d;
		if (pready !== 1'b1) begin
			csm_status_map_tb.miscompares++;
			csm_status_map_tb.complete_run();
		end
	endtask
	task automatic win();
		@(posedge pclk);
		window_start_pin <= 1'b1;
		repeat (8) @(posedge pclk);
		window_start_pin <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
endmodule

// *** sim/csm_status_map_properties.sv ***
// Checker of bus answers, reserved bits and reseed pulses
`timescale 1ns/1ps
`include "csm_defs.svh"
module csm_checker
	import csm_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire csm_sense_s  sense_in,
	input wire csm_reseed_s reseed_out
);
	wire rd_done = psel && penable && pready && !pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no access answer");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_id; rd_done && paddr == 12'h000 |-> prdata[7:0] == `CSM_PRODUCT_ID_VALUE; endproperty
	a_id: assert property (p_id) else $error("bad product id");
	property p_rev; rd_done && paddr == 12'h004 |-> prdata[7:0] == `CSM_FIRMWARE_REV_VALUE; endproperty
	a_rev: assert property (p_rev) else $error("bad revision");
	property p_flags; rd_done && paddr == 12'h040 |-> prdata[7:6] == 2'h0 && !prdata[1]; endproperty
	a_flags: assert property (p_flags) else $error("flag spare bits set");
	property p_status; rd_done && paddr == 12'h0C4 |-> prdata[7:2] == 6'h00; endproperty
	a_status: assert property (p_status) else $error("status spare bits set");
	property p_pulse; reseed_out.reseed |=> !reseed_out.reseed; endproperty
	a_pulse: assert property (p_pulse) else $error("reseed too long");
	property p_reseed; $rose(sense_in.touch) && !sense_in.prox_debounced |-> ##[2:6] reseed_out.reseed; endproperty
	a_reseed: assert property (p_reseed) else $error("missing reseed");
endmodule
bind csm_status_map csm_checker u_checker (
	.pclk       (pclk),
	.presetn    (presetn),
	.psel       (psel),
	.penable    (penable),
	.pwrite     (pwrite),
	.paddr      (paddr),
	.prdata     (prdata),
	.pready     (pready),
	.pslverr    (pslverr),
	.sense_in   (sense_in),
	.reseed_out (reseed_out)
);

// *** sim/csm_status_map_tb.sv ***
// Self-checking bench of the sensor status map
`timescale 1ns/1ps
`include "csm_defs.svh"
`define CHK(a, b) \
	begin \
		total_checks++; \
		if ((a) !== (b)) begin \
			miscompares++; \
			$display("[ERR] %0t got %h want %h", $time, (a), (b)); \
		end \
	end
module csm_status_map_tb
	import csm_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, window_start_pin, irq, e, hit;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0]  access_pointer;
	csm_sense_s  sense_in = '0;
	csm_reseed_s reseed_out;
	int          miscompares = 0;
	int          total_checks = 0;
	int          seed = 98;
	always #2.5 pclk = ~pclk;
	csm_status_map dut (
		.pclk             (pclk),
		.presetn          (presetn),
		.psel             (psel),
		.penable          (penable),
		.pwrite           (pwrite),
		.paddr            (paddr),
		.pwdata           (pwdata),
		.prdata           (prdata),
		.pready           (pready),
		.pslverr          (pslverr),
		.sense_in         (sense_in),
		.window_start_pin (window_start_pin),
		.access_pointer   (access_pointer),
		.reseed_out       (reseed_out),
		.irq              (irq)
	);
	csm_host_model host (
		.pclk             (pclk),
		.prdata           (prdata),
		.pready           (pready),
		.pslverr          (pslverr),
		.psel             (psel),
		.penable          (penable),
		.pwrite           (pwrite),
		.paddr            (paddr),
		.pwdata           (pwdata),
		.window_start_pin (window_start_pin)
	);
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		host.xfer(1'b0, a, 32'h0, q, e);
		`CHK(q, x)
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q, e);
	endtask
	task automatic put(input csm_sense_s v);
		@(posedge pclk);
		sense_in <= v;
		repeat (6) @(posedge pclk);
	endtask
	function automatic logic [31:0] flags(input csm_sense_s v);
		return {26'h0, v.polarity_high, v.ltafilter_halt, v.slow_sample_flag, v.auto_tuning, 1'b0, v.full_speed};
	endfunction
	initial begin
		csm_sense_s v;
		logic [7:0] p;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h000, {24'h0, `CSM_PRODUCT_ID_VALUE});
		wr(12'h000, 32'h5A);
		`CHK(e, 1'b0)
		rd(12'h000, {24'h0, `CSM_PRODUCT_ID_VALUE});
		rd(12'h004, {24'h0, `CSM_FIRMWARE_REV_VALUE});
		host.xfer(1'b0, 12'h7FC, 32'h0, q, e);
		`CHK(e, 1'b1)
		for (int i = 0; i < 24; i++) begin
			v = (i < 2) ? {24{i[0]}} : csm_sense_s'(24'($random(seed)));
			put(v);
			rd(12'h040, flags(v));
			rd(12'h0C4, {30'h0, v.touch, v.prox});
			rd(12'h108, {24'h0, v.count[15:8]});
			rd(12'h10C, {24'h0, v.count[7:0]});
		end
		for (int k = 0; k < 2; k++) begin
			p = k[0] ? 8'hC8 : `CSM_IDX_DETECTION_STATUS;
			wr(12'h320, {24'h0, p});
			rd(12'h320, {24'h0, p});
			host.win();
			`CHK(access_pointer, p)
		end
		wr(`CSM_OFF_LIVE_POINTER, 32'h42);
		rd(`CSM_OFF_LIVE_POINTER, 32'h42);
		host.win();
		`CHK(access_pointer, 8'hC8)
		wr(`CSM_OFF_IRQ_STATUS, 32'hF);
		for (int k = 0; k < 2; k++) begin
			v = '0;
			v.prox_debounced = k[0];
			v.count = 16'($random(seed));
			put(v);
			v.touch = 1'b1;
			sense_in <= v;
			hit = 1'b0;
			repeat (10) begin
				@(posedge pclk);
				if (reseed_out.reseed === 1'b1) begin
					hit = 1'b1;
					`CHK(reseed_out.reseed_value, v.count)
				end
			end
			`CHK(hit, ~k[0])
		end
		`CHK(irq, 1'b0)
		rd(`CSM_OFF_IRQ_STATUS, 32'h5);
		wr(`CSM_OFF_IRQ_MASK, 32'h1);
		rd(`CSM_OFF_IRQ_MASK, 32'h1);
		repeat (3) @(posedge pclk);
		`CHK(irq, 1'b1)
		wr(`CSM_OFF_IRQ_STATUS, 32'h1);
		repeat (3) @(posedge pclk);
		`CHK(irq, 1'b0)
		rd(`CSM_OFF_IRQ_STATUS, 32'h4);
		complete_run();
	end
endmodule
